/* File: logic/sss_consts.svh */
// sequencer step actions and supervision: register map, fields, timing
// assumes a 10 MHz core clock and an apb master with 32-bit data
`ifndef SSS_CONSTS_SVH
`define SSS_CONSTS_SVH
// byte offsets
`define SSS_A_CTRL 8'h00
`define SSS_A_STEPS 8'h04
`define SSS_A_WAIT 8'h08
`define SSS_A_GPO 8'h0C
`define SSS_A_GROUP 8'h10
`define SSS_A_SUP 8'h14
`define SSS_A_EVENT 8'h18
`define SSS_A_MASK 8'h1C
`define SSS_A_FAULT 8'h20
`define SSS_A_STATUS 8'h24
// field positions
`define SSS_CTRL_PWR 0
`define SSS_CTRL_TOEN 1
`define SSS_CTRL_WMODE 2
`define SSS_EV_GENERAL_INPUT_THREE 0
`define SSS_EV_TEMP 1
`define SSS_EV_SUP 2
`define SSS_F_WAIT 0
`define SSS_F_CRIT 1
`define SSS_F_UV 2
// reset values
`define SSS_STEPS_RST 24'h04_000F
`define SSS_MASK_RST 3'h7
// timing
`define SSS_CLK_NS 100
`define SSS_TICK_NS 32000
`define SSS_TICK_CYCLES (`SSS_TICK_NS / `SSS_CLK_NS)
`define SSS_WAIT_TIMEOUT_MS 500
`define SSS_WAIT_TIMEOUT_TICKS (`SSS_WAIT_TIMEOUT_MS * 1000000 / `SSS_TICK_NS)
`define SSS_UV_DEBOUNCE_MS 100
`define SSS_UV_DEBOUNCE_TICKS (`SSS_UV_DEBOUNCE_MS * 1000000 / `SSS_TICK_NS)
`define SSS_SLOT_DEFAULT_NS 128000
`define SSS_SLOT_DEFAULT (`SSS_SLOT_DEFAULT_NS / `SSS_TICK_NS)
`endif

/* File: logic/sss_pkg.sv */
// sequencer step actions and supervision: shared types
// assumes the constants header for all numeric figures
package sss_pkg;
  typedef enum logic [2:0] {
    SSS_ST_RESET = 3'h0,
    SSS_ST_IDLE = 3'h1,
    SSS_ST_UP = 3'h2,
    SSS_ST_WAIT = 3'h3,
    SSS_ST_TOP = 3'h4,
    SSS_ST_DOWN = 3'h5
  } sss_state_e;
endpackage

/* File: logic/sss_top.sv */
// sequencer step actions and supervision logic with apb registers
// assumes comparator and input pins are asynchronous, apb on core_clk
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "sss_consts.svh"
module sss_top #(
  parameter int GPO_COUNT = 2,
  parameter int TICK_CYCLES = `SSS_TICK_CYCLES,
  parameter int WAIT_TIMEOUT_TICKS = `SSS_WAIT_TIMEOUT_TICKS,
  parameter int UV_DEBOUNCE_TICKS = `SSS_UV_DEBOUNCE_TICKS
)(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic generalInputThree,
  input wire logic tempWarnCmp,
  input wire logic tempCritCmp,
  input wire logic tempPorCmp,
  input wire logic supplyLowCmp,
  input wire logic undervoltageCmp,
  input wire logic otpLoad,
  input wire logic [3:0] otpUvSel,
  input wire logic [2:0] otpHystSel,
  output logic [GPO_COUNT-1:0] gpoOut,
  output logic clockOutEnable,
  output logic [7:0] groupFuncEnable,
  output logic systemResetOutN,
  output logic supplyFaultOutN,
  output logic hostIrq,
  output logic haltFunctions,
  output logic [3:0] undervoltageThresholdSelect,
  output logic [2:0] supplyGoodHysteresisSelect
);

  // step match that ignores step zero
  function automatic logic hitStep(input logic [3:0] cur, input logic [3:0] prog);
    hitStep = (prog != 4'h0) && (cur == prog);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and filters
  logic [5:0] pins;
  logic [5:0] s1Reg, s2Reg, s3Reg, filtReg, prevReg;
  logic [5:0] rise;
  assign pins = {undervoltageCmp, supplyLowCmp, tempPorCmp, tempCritCmp, tempWarnCmp, generalInputThree};
  assign rise = filtReg & ~prevReg;

  // a change counts once stages two and three agree
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      s1Reg <= 6'h00;
      s2Reg <= 6'h00;
      s3Reg <= 6'h00;
      filtReg <= 6'h00;
      prevReg <= 6'h00;
    end
    else
    begin
      s1Reg <= pins;
      s2Reg <= s1Reg;
      s3Reg <= s2Reg;
      filtReg <= (~(s2Reg ^ s3Reg) & s3Reg) | ((s2Reg ^ s3Reg) & filtReg);
      prevReg <= filtReg;
    end
  end

  logic porFilt, uvFilt;
  assign porFilt = filtReg[3];
  assign uvFilt = filtReg[5];

  ////////////////////////////////////////////////////////////////////////////
  // 32 us tick divider
  logic [15:0] tickCntReg;
  logic tick;
  assign tick = tickCntReg == 16'(TICK_CYCLES - 1);

  always_ff @(posedge core_clk)
  begin
    if (!resetn || tick)
      tickCntReg <= 16'h0000;
    else
      tickCntReg <= tickCntReg + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [2:0] ctrlReg;
  logic [23:0] stepsReg;
  logic [15:0] waitDurReg;
  logic [17:0] gpoCfgReg;
  logic [7:0] groupSelReg;
  logic [3:0] uvSelReg;
  logic [2:0] hystReg;
  logic [2:0] evReg, evNext, evSet;
  logic [2:0] maskReg;
  logic [2:0] faultReg, faultNext, faultSet;
  logic [31:0] statusWord, rdData;
  logic wrEn, rdSetup, mapped, pwrClr;
  logic wrCtrl, wrSteps, wrWait, wrGpo, wrGroup, wrSup, wrEv, wrMask, wrFault;

  // apb decode, zero wait states
  assign wrEn = psel && penable && pwrite;
  assign rdSetup = psel && !penable;
  assign wrCtrl = wrEn && paddr == `SSS_A_CTRL;
  assign wrSteps = wrEn && paddr == `SSS_A_STEPS;
  assign wrWait = wrEn && paddr == `SSS_A_WAIT;
  assign wrGpo = wrEn && paddr == `SSS_A_GPO;
  assign wrGroup = wrEn && paddr == `SSS_A_GROUP;
  assign wrSup = wrEn && paddr == `SSS_A_SUP;
  assign wrEv = wrEn && paddr == `SSS_A_EVENT;
  assign wrMask = wrEn && paddr == `SSS_A_MASK;
  assign wrFault = wrEn && paddr == `SSS_A_FAULT;
  assign mapped = paddr[1:0] == 2'h0 && paddr <= `SSS_A_STATUS;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // read selection
  assign rdData =
    paddr == `SSS_A_CTRL ? {29'h0000_0000, ctrlReg} :
    paddr == `SSS_A_STEPS ? {8'h00, stepsReg} :
    paddr == `SSS_A_WAIT ? {16'h0000, waitDurReg} :
    paddr == `SSS_A_GPO ? {14'h0000, gpoCfgReg} :
    paddr == `SSS_A_GROUP ? {24'h00_0000, groupSelReg} :
    paddr == `SSS_A_SUP ? {25'h000_0000, hystReg, uvSelReg} :
    paddr == `SSS_A_EVENT ? {29'h0000_0000, evReg} :
    paddr == `SSS_A_MASK ? {29'h0000_0000, maskReg} :
    paddr == `SSS_A_FAULT ? {29'h0000_0000, faultReg} :
    paddr == `SSS_A_STATUS ? statusWord : 32'h0000_0000;

  // sticky flags: hardware set wins over write-one-to-clear
  assign evNext = (evReg & ~(wrEv ? pwdata[2:0] : 3'h0)) | evSet;
  assign faultNext = (faultReg & ~(wrFault ? pwdata[2:0] : 3'h0)) | faultSet;

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      ctrlReg <= 3'h0;
      stepsReg <= `SSS_STEPS_RST;
      waitDurReg <= 16'h0000;
      gpoCfgReg <= 18'h0_0000;
      groupSelReg <= 8'h00;
      uvSelReg <= 4'h0;
      hystReg <= 3'h0;
      evReg <= 3'h0;
      maskReg <= `SSS_MASK_RST;
      faultReg <= 3'h0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      if (pwrClr)
        ctrlReg[`SSS_CTRL_PWR] <= 1'b0;
      else if (wrCtrl)
        ctrlReg <= pwdata[2:0];
      if (wrCtrl && pwrClr)
        ctrlReg[2:1] <= pwdata[2:1];
      if (wrSteps)
        stepsReg <= pwdata[23:0];
      if (wrWait)
        waitDurReg <= pwdata[15:0];
      if (wrGpo)
        gpoCfgReg <= pwdata[17:0];
      if (wrGroup)
        groupSelReg <= pwdata[7:0];
      if (otpLoad)
      begin
        uvSelReg <= otpUvSel;
        hystReg <= otpHystSel;
      end
      else if (wrSup)
      begin
        uvSelReg <= pwdata[3:0];
        hystReg <= pwdata[6:4];
      end
      evReg <= evNext;
      if (wrMask)
        maskReg <= pwdata[2:0];
      faultReg <= faultNext;
      if (rdSetup)
        prdata <= rdData;
    end
  end

  // field views
  logic powerEn, timeoutEn, waitFixed;
  logic [3:0] maxStep, waitStep, clkStep, grpStep;
  logic [7:0] slotDelay, slotLen;
  assign powerEn = ctrlReg[`SSS_CTRL_PWR];
  assign timeoutEn = ctrlReg[`SSS_CTRL_TOEN];
  assign waitFixed = ctrlReg[`SSS_CTRL_WMODE];
  assign maxStep = stepsReg[3:0];
  assign waitStep = stepsReg[7:4];
  assign clkStep = stepsReg[11:8];
  assign grpStep = stepsReg[15:12];
  assign slotDelay = stepsReg[23:16];
  assign slotLen = slotDelay == 8'h00 ? 8'h01 : slotDelay;
  assign undervoltageThresholdSelect = uvSelReg;
  assign supplyGoodHysteresisSelect = hystReg;

  ////////////////////////////////////////////////////////////////////////////
  // supervision
  logic [15:0] uvCntReg;
  logic uvTrip, waitTimeout, shutReq, shutStart;
  assign uvTrip = tick && uvFilt && uvCntReg == 16'(UV_DEBOUNCE_TICKS);
  assign evSet = {rise[4], rise[1], rise[0]};
  assign faultSet = {uvTrip, rise[2], waitTimeout};

  // undervoltage debounce, saturates one past the limit so it trips once
  always_ff @(posedge core_clk)
  begin
    if (!resetn || !uvFilt)
      uvCntReg <= 16'h0000;
    else if (tick && uvCntReg <= 16'(UV_DEBOUNCE_TICKS))
      uvCntReg <= uvCntReg + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  sss_pkg::sss_state_e stateReg, stateNext;
  logic [3:0] stepReg, stepNext;
  logic dirUpReg, dirUpNext, toResetReg, toResetNext, arriveReg, arriveNext;
  logic waitPassedReg, waitPass, slotDone, inReset;
  logic [7:0] slotCntReg;
  logic [15:0] waitCntReg;
  logic [GPO_COUNT-1:0] gpoActReg, gpoPol;
  logic clkOutReg, grpReg, resetActReg, haltReg, irqReg;

  assign inReset = stateReg == sss_pkg::SSS_ST_RESET;
  assign slotDone = tick && (slotCntReg + 8'h01 >= slotLen);
  assign waitPass = waitFixed ? (tick && waitCntReg >= waitDurReg) : evReg[`SSS_EV_GENERAL_INPUT_THREE];
  assign waitTimeout = stateReg == sss_pkg::SSS_ST_WAIT && !waitFixed && !waitPass && timeoutEn && tick
    && waitCntReg >= 16'(WAIT_TIMEOUT_TICKS - 1);
  assign shutReq = rise[2] || uvTrip || waitTimeout;
  assign shutStart = shutReq && !inReset && !(stateReg == sss_pkg::SSS_ST_DOWN && toResetReg);

  // next state, with instant reset above any sequenced shutdown
  always_comb
  begin
    stateNext = stateReg;
    stepNext = stepReg;
    dirUpNext = dirUpReg;
    toResetNext = toResetReg;
    arriveNext = 1'b0;
    pwrClr = 1'b0;
    if (porFilt)
    begin
      stateNext = sss_pkg::SSS_ST_RESET;
      stepNext = 4'h0;
      toResetNext = 1'b0;
      pwrClr = 1'b1;
    end
    else if (shutStart)
    begin
      stateNext = sss_pkg::SSS_ST_DOWN;
      dirUpNext = 1'b0;
      toResetNext = 1'b1;
      // the step in hand is acted on again, going down
      arriveNext = stateReg != sss_pkg::SSS_ST_DOWN;
      pwrClr = 1'b1;
    end
    else
    begin
      unique case (stateReg)
        sss_pkg::SSS_ST_RESET, sss_pkg::SSS_ST_IDLE:
          if (powerEn)
          begin
            stateNext = sss_pkg::SSS_ST_UP;
            dirUpNext = 1'b1;
          end
        sss_pkg::SSS_ST_UP:
          if (!powerEn)
          begin
            stateNext = sss_pkg::SSS_ST_DOWN;
            dirUpNext = 1'b0;
            arriveNext = 1'b1;
          end
          else if (slotDone)
          begin
            if (hitStep(stepReg, waitStep) && !waitPassedReg)
              stateNext = sss_pkg::SSS_ST_WAIT;
            else if (stepReg >= maxStep)
              stateNext = sss_pkg::SSS_ST_TOP;
            else
            begin
              stepNext = stepReg + 4'h1;
              arriveNext = 1'b1;
            end
          end
        sss_pkg::SSS_ST_WAIT:
          if (!powerEn)
          begin
            stateNext = sss_pkg::SSS_ST_DOWN;
            dirUpNext = 1'b0;
            arriveNext = 1'b1;
          end
          else if (waitPass)
            stateNext = sss_pkg::SSS_ST_UP;
        sss_pkg::SSS_ST_TOP:
          if (!powerEn)
          begin
            stateNext = sss_pkg::SSS_ST_DOWN;
            dirUpNext = 1'b0;
            arriveNext = 1'b1;
          end
        sss_pkg::SSS_ST_DOWN:
          if (slotDone)
          begin
            if (stepReg == 4'h0)
              stateNext = toResetReg ? sss_pkg::SSS_ST_RESET : sss_pkg::SSS_ST_IDLE;
            else
            begin
              stepNext = stepReg - 4'h1;
              arriveNext = 1'b1;
            end
          end
        default:
          stateNext = sss_pkg::SSS_ST_RESET;
      endcase
    end
  end

  // sequencer state registers
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      stateReg <= sss_pkg::SSS_ST_RESET;
      stepReg <= 4'h0;
      dirUpReg <= 1'b1;
      toResetReg <= 1'b0;
      arriveReg <= 1'b0;
    end
    else
    begin
      stateReg <= stateNext;
      stepReg <= stepNext;
      dirUpReg <= dirUpNext;
      toResetReg <= toResetNext;
      arriveReg <= arriveNext;
    end
  end

  // slot and wait counters
  always_ff @(posedge core_clk)
  begin
    if (!resetn || slotDone || stateNext != stateReg)
      slotCntReg <= 8'h00;
    else if (tick)
      slotCntReg <= slotCntReg + 8'h01;
    if (!resetn || stateReg != sss_pkg::SSS_ST_WAIT)
      waitCntReg <= 16'h0000;
    else if (tick)
      waitCntReg <= waitCntReg + 16'h0001;
    if (!resetn || stateReg == sss_pkg::SSS_ST_RESET || stateReg == sss_pkg::SSS_ST_IDLE)
      waitPassedReg <= 1'b0;
    else if (stateReg == sss_pkg::SSS_ST_WAIT && stateNext == sss_pkg::SSS_ST_UP)
      waitPassedReg <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // step actions: outputs, clock out, group enable
  always_ff @(posedge core_clk)
  begin
    if (!resetn || inReset)
    begin
      gpoActReg <= '0;
      clkOutReg <= 1'b0;
      grpReg <= 1'b0;
    end
    else if (arriveReg)
    begin
      for (int i = 0; i < GPO_COUNT; i++)
      begin
        if (hitStep(stepReg, gpoCfgReg[i*8 +: 4]))
          gpoActReg[i] <= dirUpReg;
        else if (hitStep(stepReg, gpoCfgReg[i*8+4 +: 4]))
          gpoActReg[i] <= !dirUpReg;
      end
      if (hitStep(stepReg, clkStep))
        clkOutReg <= dirUpReg;
      if (dirUpReg && stepReg > grpStep)
        grpReg <= 1'b1;
      else if (!dirUpReg && stepReg < grpStep)
        grpReg <= 1'b0;
    end
  end

  // reset output, halt and interrupt
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      resetActReg <= 1'b1;
      haltReg <= 1'b0;
      irqReg <= 1'b0;
    end
    else
    begin
      if (porFilt || shutStart)
        resetActReg <= 1'b1;
      else if (stateNext == sss_pkg::SSS_ST_TOP)
        resetActReg <= 1'b0;
      haltReg <= porFilt;
      irqReg <= |(evNext & ~maskReg);
    end
  end

  // polarity 1 drives active high, 0 active low
  assign gpoPol = gpoCfgReg[16 +: GPO_COUNT];
  assign gpoOut = ~(gpoActReg ^ gpoPol);
  assign clockOutEnable = clkOutReg;
  assign groupFuncEnable = ~groupSelReg | {8{grpReg}};
  assign systemResetOutN = !resetActReg;
  assign supplyFaultOutN = !filtReg[5];
  assign hostIrq = irqReg;
  assign haltFunctions = haltReg;
  assign statusWord = {8'h00, 8'(gpoActReg), 5'h00, uvFilt, grpReg, clkOutReg, dirUpReg, stateReg, stepReg};

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence waitExpire;
    waitTimeout && !porFilt;
  endsequence
  sequence downToReset;
    stateReg == sss_pkg::SSS_ST_DOWN && toResetReg && faultReg[`SSS_F_WAIT];
  endsequence

  gpo_reset_hold_a: assert property (inReset && $past(inReset) |-> gpoOut == ~gpoPol)
    else $error("output not inactive in reset mode");
  gpo_step_only_a: assert property (!arriveReg && !inReset |=> inReset || $stable(gpoActReg))
    else $error("output moved without a step arrival");
  gpo_step_zero_a: assert property (arriveReg && stepReg == 4'h0 && !inReset |=> inReset || $stable(gpoActReg))
    else $error("output moved at step zero");
  wait_timeout_a: assert property (waitExpire |=> downToReset)
    else $error("wait timeout did not start shutdown");
  crit_reset_a: assert property (rise[2] && !porFilt |=> !systemResetOutN && faultReg[`SSS_F_CRIT])
    else $error("critical temperature did not assert reset");
  por_priority_a: assert property (porFilt |=> inReset && haltFunctions)
    else $error("highest temperature did not enter reset");
  uv_fault_out_a: assert property (s2Reg[5] && s3Reg[5] |=> !supplyFaultOutN)
    else $error("supply fault output not asserted");
  temp_event_a: assert property (rise[1] |=> evReg[`SSS_EV_TEMP] [*2])
    else $error("warning event lost");
  clk_out_up_a: assert property (arriveReg && dirUpReg && hitStep(stepReg, clkStep) && !porFilt
    |=> clockOutEnable)
    else $error("clock out not enabled at its step");
  clk_out_down_a: assert property (arriveReg && !dirUpReg && hitStep(stepReg, clkStep) |=> !clockOutEnable)
    else $error("clock out not disabled at its step");
  step_down_a: assert property (stateReg == sss_pkg::SSS_ST_DOWN && slotDone && stepReg != 4'h0 && !porFilt
    && !shutStart |=> stepReg == $past(stepReg) - 4'h1)
    else $error("power-down did not step back");

endmodule // sss_top

/* File: verification/sss_pins_model.sv */
// pin environment model: temperature and supply comparators, input three
// assumes the bench sets requested levels just after a rising edge
`timescale 1ns/1ps
module sss_pins_model (
  input wire logic core_clk,
  input wire logic [5:0] pinReq,
  output logic generalInputThree,
  output logic tempWarnCmp,
  output logic tempCritCmp,
  output logic tempPorCmp,
  output logic supplyLowCmp,
  output logic undervoltageCmp
);
  // levels follow the request one edge late, like a slow comparator
  initial {undervoltageCmp, supplyLowCmp, tempPorCmp, tempCritCmp, tempWarnCmp, generalInputThree} = 6'h00;
  always @(posedge core_clk)
  begin
    {undervoltageCmp, supplyLowCmp, tempPorCmp, tempCritCmp, tempWarnCmp, generalInputThree} <= pinReq;
  end
endmodule // sss_pins_model

/* File: verification/sss_top_test.sv */
// self-checking bench for the step actions and supervision block
// assumes 10 MHz core_clk, shortened tick, timeout and debounce counts
`timescale 1ns/1ps
`include "sss_consts.svh"
module sss_top_test;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [5:0] pinReq = 6'h00;
  logic generalInputThree, tempWarnCmp, tempCritCmp, tempPorCmp, supplyLowCmp, undervoltageCmp;
  logic otpLoad = 1'b0;
  logic [3:0] otpUvSel = 4'h0;
  logic [2:0] otpHystSel = 3'h0;
  logic [1:0] gpoOut;
  logic [7:0] groupFuncEnable;
  logic [3:0] uvSel;
  logic [2:0] hystSel;
  logic clockOutEnable, systemResetOutN, supplyFaultOutN, hostIrq, haltFunctions;
  logic [31:0] q;
  logic qErr;
  int err_total = 0;
  int comparisons = 0;

  ////////////////////////////////////////////////////////////////////////
  // clock, pin model and design
  initial
  begin
    forever #50 core_clk = ~core_clk;
  end
  sss_pins_model i_sss_pins_model (.core_clk(core_clk), .pinReq(pinReq),
    .generalInputThree(generalInputThree), .tempWarnCmp(tempWarnCmp), .tempCritCmp(tempCritCmp),
    .tempPorCmp(tempPorCmp), .supplyLowCmp(supplyLowCmp), .undervoltageCmp(undervoltageCmp));
  sss_top #(.GPO_COUNT(2), .TICK_CYCLES(4), .WAIT_TIMEOUT_TICKS(20), .UV_DEBOUNCE_TICKS(10)) i_sss_top (
    .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .generalInputThree(generalInputThree), .tempWarnCmp(tempWarnCmp), .tempCritCmp(tempCritCmp),
    .tempPorCmp(tempPorCmp), .supplyLowCmp(supplyLowCmp), .undervoltageCmp(undervoltageCmp),
    .otpLoad(otpLoad), .otpUvSel(otpUvSel), .otpHystSel(otpHystSel), .gpoOut(gpoOut),
    .clockOutEnable(clockOutEnable), .groupFuncEnable(groupFuncEnable), .systemResetOutN(systemResetOutN),
    .supplyFaultOutN(supplyFaultOutN), .hostIrq(hostIrq), .haltFunctions(haltFunctions),
    .undervoltageThresholdSelect(uvSel), .supplyGoodHysteresisSelect(hystSel));

  ////////////////////////////////////////////////////////////////////////
  // apb master, compares and polling
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    q = prdata;
    qErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkb(input string what, input logic exp, input logic got);
    chk(what, {31'h0000_0000, exp}, {31'h0000_0000, got});
  endtask
  // poll the state field, bounded
  task automatic wait_state(input logic [2:0] s);
    int n;
    n = 0;
    rd(`SSS_A_STATUS);
    while (q[6:4] !== s && n < 300)
    begin
      rd(`SSS_A_STATUS);
      n++;
    end
    chk("state", {29'h0000_0000, s}, {29'h0000_0000, q[6:4]});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    chk("gpo", 32'h0000_0003, {30'h0000_0000, gpoOut});
    rd(`SSS_A_STEPS);
    chkb("pready", 1'b1, pready);
    chk("steps", `SSS_STEPS_RST, q);
    rd(`SSS_A_MASK);
    chk("mask", 32'h0000_0007, q);
    rd(8'h28);
    chkb("slverr", 1'b1, qErr);
    wr(`SSS_A_GPO, 32'h0001_1002);
    wr(`SSS_A_STEPS, 32'h0004_2303);
    wr(`SSS_A_GROUP, 32'h0000_000F);
    idle(3);
    chk("gpo", 32'h0000_0002, {30'h0000_0000, gpoOut});
    chk("group", 32'h0000_00F0, {24'h00_0000, groupFuncEnable});
    $display("t_reset done");
  endtask
  task automatic t_updown();
    wr(`SSS_A_CTRL, 32'h0000_0001);
    wait_state(3'h4);
    idle(4);
    chk("gpo", 32'h0000_0003, {30'h0000_0000, gpoOut});
    chkb("clkout", 1'b1, clockOutEnable);
    chk("group", 32'h0000_00FF, {24'h00_0000, groupFuncEnable});
    chkb("resetout", 1'b1, systemResetOutN);
    wr(`SSS_A_CTRL, 32'h0000_0000);
    wait_state(3'h1);
    idle(4);
    chk("gpo", 32'h0000_0000, {30'h0000_0000, gpoOut});
    chkb("clkout", 1'b0, clockOutEnable);
    chk("group", 32'h0000_00F0, {24'h00_0000, groupFuncEnable});
    $display("t_updown done");
  endtask
  task automatic t_timeout();
    wr(`SSS_A_STEPS, 32'h0004_2323);
    wr(`SSS_A_CTRL, 32'h0000_0003);
    wait_state(3'h3);
    wait_state(3'h0);
    rd(`SSS_A_FAULT);
    chk("fault", 32'h0000_0001, q);
    chk("gpo", 32'h0000_0002, {30'h0000_0000, gpoOut});
    chkb("resetout", 1'b0, systemResetOutN);
    wr(`SSS_A_FAULT, 32'h0000_0001);
    rd(`SSS_A_FAULT);
    chk("fault", 32'h0000_0000, q);
    $display("t_timeout done");
  endtask
  task automatic t_event();
    wr(`SSS_A_CTRL, 32'h0000_0001);
    wait_state(3'h3);
    idle(20);
    rd(`SSS_A_STATUS);
    chk("state", 32'h0000_0003, {29'h0000_0000, q[6:4]});
    pinReq <= 6'h01;
    idle(8);
    pinReq <= 6'h00;
    wait_state(3'h4);
    rd(`SSS_A_EVENT);
    chk("event", 32'h0000_0001, q);
    wr(`SSS_A_EVENT, 32'h0000_0001);
    rd(`SSS_A_EVENT);
    chk("event", 32'h0000_0000, q);
    $display("t_event done");
  endtask
  task automatic t_temp();
    pinReq <= 6'h02;
    idle(8);
    rd(`SSS_A_EVENT);
    chk("event", 32'h0000_0002, q);
    chkb("irq", 1'b0, hostIrq);
    wr(`SSS_A_MASK, 32'h0000_0000);
    idle(3);
    chkb("irq", 1'b1, hostIrq);
    wr(`SSS_A_EVENT, 32'h0000_0002);
    idle(3);
    chkb("irq", 1'b0, hostIrq);
    pinReq <= 6'h04;
    idle(8);
    chkb("resetout", 1'b0, systemResetOutN);
    rd(`SSS_A_STATUS);
    chk("state", 32'h0000_0005, {29'h0000_0000, q[6:4]});
    wait_state(3'h0);
    pinReq <= 6'h00;
    wr(`SSS_A_WAIT, 32'h0000_0006);
    wr(`SSS_A_CTRL, 32'h0000_0005);
    wait_state(3'h3);
    wait_state(3'h4);
    rd(`SSS_A_FAULT);
    chk("fault", 32'h0000_0002, q);
    wr(`SSS_A_FAULT, 32'h0000_0002);
    $display("t_temp done");
  endtask
  task automatic t_supply();
    pinReq <= 6'h10;
    idle(8);
    rd(`SSS_A_EVENT);
    chk("event", 32'h0000_0004, q);
    chkb("irq", 1'b1, hostIrq);
    pinReq <= 6'h30;
    idle(8);
    chkb("supplyfault", 1'b0, supplyFaultOutN);
    rd(`SSS_A_FAULT);
    chk("fault", 32'h0000_0000, q);
    wait_state(3'h0);
    rd(`SSS_A_FAULT);
    chk("fault", 32'h0000_0004, q);
    chkb("resetout", 1'b0, systemResetOutN);
    pinReq <= 6'h00;
    wr(`SSS_A_EVENT, 32'h0000_0004);
    wr(`SSS_A_FAULT, 32'h0000_0004);
    idle(8);
    chkb("supplyfault", 1'b1, supplyFaultOutN);
    otpUvSel <= 4'hA;
    otpHystSel <= 3'h5;
    otpLoad <= 1'b1;
    idle(1);
    otpLoad <= 1'b0;
    idle(2);
    chk("otpsel", 32'h0000_005A, {25'h000_0000, hystSel, uvSel});
    rd(`SSS_A_SUP);
    chk("sup", 32'h0000_005A, q);
    $display("t_supply done");
  endtask
  task automatic t_por();
    wr(`SSS_A_CTRL, 32'h0000_0005);
    wait_state(3'h4);
    pinReq <= 6'h04;
    idle(8);
    pinReq <= 6'h0C;
    idle(8);
    rd(`SSS_A_STATUS);
    chk("state", 32'h0000_0000, {29'h0000_0000, q[6:4]});
    chkb("halt", 1'b1, haltFunctions);
    chk("gpo", 32'h0000_0002, {30'h0000_0000, gpoOut});
    pinReq <= 6'h00;
    $display("t_por done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // verdict, main sequence and watchdog
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset();
    t_updown();
    t_timeout();
    t_event();
    t_temp();
    t_supply();
    t_por();
    test_done();
  end
  initial
  begin
    #4000000;
    err_total++;
    test_done();
  end
endmodule // sss_top_test
